// >>> src/alag_pkg.sv
// package: register indices, field positions and reset values of the alarm aggregator
`default_nettype none
package alag_pkg;
    // register indices; byte address is four times the index
    localparam int ALAG_AW = 12;
    localparam int ALAG_IW = 10;
    localparam logic [9:0] ALAG_IDX_SUMMARY = 10'h2C0;
    localparam logic [9:0] ALAG_IDX_FLAGS = 10'h2C1;
    localparam logic [9:0] ALAG_IDX_MASK = 10'h2C2;
    localparam logic [9:0] ALAG_IDX_LANE = 10'h2C4;
    localparam logic [9:0] ALAG_IDX_CTRL = 10'h2C8;
    localparam logic [9:0] ALAG_IDX_IEN = 10'h2C9;
    localparam logic [9:0] ALAG_IDX_ICLR = 10'h2CA;
    localparam logic [9:0] ALAG_IDX_ISTAT = 10'h2CB;
    // alert flag bit positions
    localparam int ALAG_BIT_FIFO = 5;
    localparam int ALAG_BIT_SPLL = 4;
    localparam int ALAG_BIT_LINK = 3;
    localparam int ALAG_BIT_REALN = 2;
    localparam int ALAG_BIT_RSVD = 1;
    localparam int ALAG_BIT_CLK = 0;
    // control register bit positions
    localparam int ALAG_CTL_LINK_EN = 0;
    localparam int ALAG_CTL_MODE66 = 1;
    localparam int ALAG_CTL_PIN_SEL = 2;
    localparam int ALAG_CTL_SOFT_RST = 7;
    // reset values and field masks
    localparam logic [7:0] ALAG_FLAGS_RST = 8'h3F;
    localparam logic [7:0] ALAG_MASK_RST = 8'h3F;
    localparam logic [7:0] ALAG_LANE_RST = 8'hFF;
    localparam logic [7:0] ALAG_CTRL_RST = 8'h00;
    localparam logic [7:0] ALAG_IEN_RST = 8'h00;
    localparam logic [7:0] ALAG_ISTAT_RST = 8'h00;
    localparam logic [7:0] ALAG_ALARM_BITS = 8'h3D;

    // write strobe aimed at one register index
    function automatic logic alag_hit(input logic wr, input logic [9:0] idx,
                                      input logic [9:0] tgt);
        return wr && (idx == tgt);
    endfunction : alag_hit
endpackage : alag_pkg
`default_nettype wire

// >>> src/alag_reg_if.sv
// interface: register strobes between the bus slave and the register file
`default_nettype none
interface alag_reg_if;
    logic wr_stb;
    logic [9:0] idx;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport bus (output wr_stb, output idx, output wdata, input rdata);
    modport regs (input wr_stb, input idx, input wdata, output rdata);
endinterface : alag_reg_if
`default_nettype wire

// >>> src/alag_wb_slave.sv
// module: classic wishbone slave, one wait state, registered read data
`default_nettype none
module alag_wb_slave
    import alag_pkg::*;
(
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [ALAG_AW-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    alag_reg_if.bus rif
);
    typedef struct packed {
        logic ack;
        logic [7:0] dat;
    } alag_wb_s;

    alag_wb_s state_q;
    alag_wb_s state_d;
    logic req;

    // request decode; low byte lane carries the register data
    assign req = wb_cyc_in && wb_stb_in;
    assign rif.idx = wb_adr_in[ALAG_AW-1:2];
    assign rif.wdata = wb_dat_in[7:0];
    assign rif.wr_stb = req && wb_we_in && wb_sel_in[0] && state_q.ack;
    assign wb_ack_out = state_q.ack;
    assign wb_dat_out = {24'h000000, state_q.dat};

    // ack one cycle after the request, dropped the cycle after
    always_comb begin
        state_d = state_q;
        state_d.ack = req && !state_q.ack;
        if (req && !state_q.ack) begin
            state_d.dat = rif.rdata;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end
endmodule : alag_wb_slave
`default_nettype wire

// >>> src/alag_flag_bank.sv
// module: bank of sticky write-one-to-clear flags, set beats clear
`default_nettype none
module alag_flag_bank
    import alag_pkg::*;
#(
    parameter int W = 8,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] set_in,
    input wire logic [W-1:0] clr_in,
    input wire logic reinit_in,
    output logic [W-1:0] flags_out
);
    typedef struct packed {
        logic [W-1:0] flags;
    } alag_bank_s;

    alag_bank_s state_q;
    alag_bank_s state_d;

    assign flags_out = state_q.flags;

    // reinit restores reset value, otherwise clear then set
    always_comb begin
        state_d = state_q;
        if (reinit_in) begin
            // an event in the reinit cycle is still kept
            state_d.flags = RST | set_in;
        end else begin
            state_d.flags = (state_q.flags & ~clr_in) | set_in;
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q.flags <= RST;
        end else begin
            state_q <= state_d;
        end
    end
endmodule : alag_flag_bank
`default_nettype wire

// >>> src/alag_top.sv
// module: alarm aggregator top, register file, flag sources and alarm outputs
//
// Design decision made here: the Wishbone slave port.
`default_nettype none
module alag_top
    import alag_pkg::*;
#(
    parameter int LANES = 8
) (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic wb_cyc_in,
    input wire logic wb_stb_in,
    input wire logic wb_we_in,
    input wire logic [ALAG_AW-1:0] wb_adr_in,
    input wire logic [3:0] wb_sel_in,
    input wire logic [31:0] wb_dat_in,
    output logic [31:0] wb_dat_out,
    output logic wb_ack_out,
    input wire logic [LANES-1:0] lane_fifo_err_in,
    input wire logic [LANES-1:0] lane_active_in,
    input wire logic spll_locked_in,
    input wire logic link_data_state_in,
    input wire logic link_realign_in,
    input wire logic sysref_realign_in,
    input wire logic div_mismatch_in,
    input wire logic cal_status_in,
    output logic status_output_pin_out,
    output logic irq_out
);
    typedef struct packed {
        logic [7:0] mask;
        logic [7:0] ien;
        logic link_en;
        logic mode66;
        logic pin_sel;
        logic link_en_prev;
        logic soft_rst;
    } alag_ctl_s;

    alag_ctl_s state_q;
    alag_ctl_s state_d;
    alag_reg_if rif ();

    logic [7:0] flags_q;
    logic [7:0] lanes_q;
    logic [7:0] istat_q;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    logic [7:0] lane_set;
    logic [7:0] lane_clr;
    logic [7:0] irq_clr;
    logic wr_flags;
    logic wr_lane;
    logic wr_ctrl;
    logic link_start;
    logic summary;

    // register write strobes
    assign wr_flags = alag_hit(rif.wr_stb, rif.idx, ALAG_IDX_FLAGS);
    assign wr_lane = alag_hit(rif.wr_stb, rif.idx, ALAG_IDX_LANE);
    assign wr_ctrl = alag_hit(rif.wr_stb, rif.idx, ALAG_IDX_CTRL);

    // lane errors count only on active lanes with the link on
    always_comb begin
        lane_set = '0;
        lane_set[LANES-1:0] = lane_fifo_err_in & lane_active_in
                              & {LANES{state_q.link_en}};
    end

    // link startup seen as enable rising
    assign link_start = state_q.link_en && !state_q.link_en_prev;

    // flag set conditions; set wins over clear in the bank
    always_comb begin
        flag_set = '0;
        flag_set[ALAG_BIT_FIFO] = |lane_set;
        flag_set[ALAG_BIT_SPLL] = state_q.link_en && !spll_locked_in;
        if (state_q.mode66) begin
            flag_set[ALAG_BIT_LINK] = state_q.link_en
                                      && (link_start || link_realign_in);
        end else begin
            flag_set[ALAG_BIT_LINK] = state_q.link_en && !link_data_state_in;
        end
        flag_set[ALAG_BIT_REALN] = state_q.link_en && sysref_realign_in;
        flag_set[ALAG_BIT_CLK] = div_mismatch_in;
    end

    // write-one-to-clear strobes
    assign flag_clr = wr_flags ? rif.wdata : 8'h00;
    assign lane_clr = (wr_lane ? rif.wdata : 8'h00)
                      | ((wr_flags && rif.wdata[ALAG_BIT_FIFO]) ? 8'hFF : 8'h00);
    assign irq_clr = alag_hit(rif.wr_stb, rif.idx, ALAG_IDX_ICLR) ? rif.wdata : 8'h00;

    // alert flags, power-on and soft reset to 3F, bits 5 to 0 set
    alag_flag_bank #(
        .W(8),
        .RST(ALAG_FLAGS_RST)
    ) u_flags (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(flag_set),
        .clr_in(flag_clr),
        .reinit_in(state_q.soft_rst),
        .flags_out(flags_q)
    );

    // per-lane fifo error flags
    alag_flag_bank #(
        .W(8),
        .RST(ALAG_LANE_RST)
    ) u_lanes (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(lane_set),
        .clr_in(lane_clr),
        .reinit_in(state_q.soft_rst),
        .flags_out(lanes_q)
    );

    // interrupt status, set by each flag event
    alag_flag_bank #(
        .W(8),
        .RST(ALAG_ISTAT_RST)
    ) u_istat (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .set_in(flag_set & ALAG_ALARM_BITS),
        .clr_in(irq_clr),
        .reinit_in(state_q.soft_rst),
        .flags_out(istat_q)
    );

    // wishbone slave
    alag_wb_slave u_wb (
        .mclk_in(mclk_in),
        .rst_in(rst_in),
        .wb_cyc_in(wb_cyc_in),
        .wb_stb_in(wb_stb_in),
        .wb_we_in(wb_we_in),
        .wb_adr_in(wb_adr_in),
        .wb_sel_in(wb_sel_in),
        .wb_dat_in(wb_dat_in),
        .wb_dat_out(wb_dat_out),
        .wb_ack_out(wb_ack_out),
        .rif(rif.bus)
    );

    // summary alarm and its pin routing
    assign summary = |(flags_q & ~state_q.mask & ALAG_ALARM_BITS);
    assign status_output_pin_out = state_q.pin_sel ? summary : cal_status_in;
    assign irq_out = |(istat_q & state_q.ien);

    // control registers; soft reset is a one-cycle pulse
    always_comb begin
        state_d = state_q;
        state_d.link_en_prev = state_q.link_en;
        state_d.soft_rst = wr_ctrl && rif.wdata[ALAG_CTL_SOFT_RST];
        if (state_q.soft_rst) begin
            state_d.mask = ALAG_MASK_RST;
        end else if (alag_hit(rif.wr_stb, rif.idx, ALAG_IDX_MASK)) begin
            state_d.mask = rif.wdata;
        end
        if (alag_hit(rif.wr_stb, rif.idx, ALAG_IDX_IEN)) begin
            state_d.ien = rif.wdata;
        end
        if (wr_ctrl) begin
            state_d.link_en = rif.wdata[ALAG_CTL_LINK_EN];
            state_d.mode66 = rif.wdata[ALAG_CTL_MODE66];
            state_d.pin_sel = rif.wdata[ALAG_CTL_PIN_SEL];
        end
    end

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q.mask <= ALAG_MASK_RST;
            state_q.ien <= ALAG_IEN_RST;
            state_q.link_en <= ALAG_CTRL_RST[ALAG_CTL_LINK_EN];
            state_q.mode66 <= ALAG_CTRL_RST[ALAG_CTL_MODE66];
            state_q.pin_sel <= ALAG_CTRL_RST[ALAG_CTL_PIN_SEL];
            state_q.link_en_prev <= 1'b0;
            state_q.soft_rst <= 1'b0;
        end else begin
            state_q <= state_d;
        end
    end

    // read data mux; unmapped and write-only indices read zero
    always_comb begin
        rif.rdata = 8'h00;
        unique case (rif.idx)
            ALAG_IDX_SUMMARY: rif.rdata = {7'h00, summary};
            ALAG_IDX_FLAGS: rif.rdata = flags_q;
            ALAG_IDX_MASK: rif.rdata = state_q.mask;
            ALAG_IDX_LANE: rif.rdata = lanes_q;
            ALAG_IDX_CTRL: rif.rdata = {5'h00, state_q.pin_sel, state_q.mode66,
                                        state_q.link_en};
            ALAG_IDX_IEN: rif.rdata = state_q.ien;
            ALAG_IDX_ISTAT: rif.rdata = istat_q;
            default: rif.rdata = 8'h00;
        endcase
    end

    // checks on flag behaviour
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (rst_in);

    property p_summary_follows;
        (flags_q[ALAG_BIT_SPLL] && !state_q.mask[ALAG_BIT_SPLL])
            |-> (rif.idx != ALAG_IDX_SUMMARY) || (rif.rdata == 8'h01);
    endproperty
    a_summary_follows: assert property (p_summary_follows)
        else $error("summary bit low with unmasked flag set");

    property p_summary_masked;
        ((state_q.mask & ALAG_ALARM_BITS) == ALAG_ALARM_BITS) |-> !summary;
    endproperty
    a_summary_masked: assert property (p_summary_masked)
        else $error("summary high with all flags masked");

    property p_pin_route;
        state_q.pin_sel |-> (status_output_pin_out == summary);
    endproperty
    a_pin_route: assert property (p_pin_route)
        else $error("status pin not carrying summary");

    property p_lane_sets;
        (|lane_set) |=> (flags_q[ALAG_BIT_FIFO] && (lanes_q != 8'h00));
    endproperty
    a_lane_sets: assert property (p_lane_sets)
        else $error("lane fifo error did not set flags");

    property p_spll_sets;
        (state_q.link_en && !spll_locked_in) |=> flags_q[ALAG_BIT_SPLL];
    endproperty
    a_spll_sets: assert property (p_spll_sets)
        else $error("pll unlock did not set flag");

    property p_link8_sets;
        (state_q.link_en && !state_q.mode66 && !link_data_state_in)
            |=> flags_q[ALAG_BIT_LINK];
    endproperty
    a_link8_sets: assert property (p_link8_sets)
        else $error("link not in data did not set flag");

    property p_link66_start;
        (state_q.mode66 && $rose(state_q.link_en)) |=> flags_q[ALAG_BIT_LINK];
    endproperty
    a_link66_start: assert property (p_link66_start)
        else $error("link startup did not set flag");

    property p_realign_sets;
        (state_q.link_en && sysref_realign_in) |=> flags_q[ALAG_BIT_REALN];
    endproperty
    a_realign_sets: assert property (p_realign_sets)
        else $error("sysref realignment did not set flag");

    property p_clk_sets;
        div_mismatch_in |=> flags_q[ALAG_BIT_CLK];
    endproperty
    a_clk_sets: assert property (p_clk_sets)
        else $error("divider mismatch did not set flag");

    property p_w1c_clears;
        (wr_flags && rif.wdata[ALAG_BIT_REALN] && !flag_set[ALAG_BIT_REALN]
            && !state_q.soft_rst) |=> !flags_q[ALAG_BIT_REALN];
    endproperty
    a_w1c_clears: assert property (p_w1c_clears)
        else $error("write one did not clear flag");

    property p_w0_keeps;
        (wr_flags && !rif.wdata[ALAG_BIT_CLK] && flags_q[ALAG_BIT_CLK])
            |=> flags_q[ALAG_BIT_CLK];
    endproperty
    a_w0_keeps: assert property (p_w0_keeps)
        else $error("write zero changed flag");

    property p_soft_reset;
        $rose(state_q.soft_rst) |=> (flags_q == ALAG_FLAGS_RST)
            && (state_q.mask == ALAG_MASK_RST) && (lanes_q == ALAG_LANE_RST);
    endproperty
    a_soft_reset: assert property (p_soft_reset)
        else $error("soft reset did not restore flags and mask");

    property p_fifo_clears_lanes;
        (wr_flags && rif.wdata[ALAG_BIT_FIFO] && !(|lane_set) && !state_q.soft_rst)
            |=> (lanes_q == 8'h00);
    endproperty
    a_fifo_clears_lanes: assert property (p_fifo_clears_lanes)
        else $error("fifo flag clear left lane bits set");

    property p_set_beats_clear;
        (wr_flags && rif.wdata[ALAG_BIT_SPLL] && flag_set[ALAG_BIT_SPLL])
            |=> flags_q[ALAG_BIT_SPLL] && (summary || state_q.mask[ALAG_BIT_SPLL]);
    endproperty
    a_set_beats_clear: assert property (p_set_beats_clear)
        else $error("clear won over same-cycle set");

    property p_irq_level;
        (|(istat_q & state_q.ien)) |-> irq_out ##1 (irq_out || $past(|irq_clr)
            || $past(state_q.soft_rst) || (state_q.ien != $past(state_q.ien)));
    endproperty
    a_irq_level: assert property (p_irq_level)
        else $error("interrupt dropped without a clear");

    c_summary_pin: cover property (state_q.pin_sel ##1 $rose(status_output_pin_out));
    c_lane_clear: cover property ((|lanes_q) ##1 (wr_flags && rif.wdata[ALAG_BIT_FIFO]));
    c_link66: cover property (state_q.mode66 && link_realign_in && state_q.link_en);
    c_soft_rst: cover property ($rose(state_q.soft_rst));
endmodule : alag_top
`default_nettype wire

// >>> tb/tb_alag_top.sv
// testbench: self-checking register and alarm scenarios for the alarm aggregator
`default_nettype none
module tb_alag_top;
    import alag_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk_in = 1'b0;
    logic rst_in = 1'b1;
    logic wb_cyc_in = 1'b0;
    logic wb_stb_in = 1'b0;
    logic wb_we_in = 1'b0;
    logic [ALAG_AW-1:0] wb_adr_in = '0;
    logic [3:0] wb_sel_in = 4'hF;
    logic [31:0] wb_dat_in = '0;
    logic [31:0] wb_dat_out;
    logic wb_ack_out;
    logic [7:0] lane_fifo_err_in = 8'h00;
    logic [7:0] lane_active_in = 8'hFF;
    logic spll_locked_in = 1'b1;
    logic link_data_state_in = 1'b1;
    logic link_realign_in = 1'b0;
    logic sysref_realign_in = 1'b0;
    logic div_mismatch_in = 1'b0;
    logic cal_status_in = 1'b1;
    logic status_output_pin_out;
    logic irq_out;
    int n_errors = 0;
    int checked = 0;
    int cycles = 0;
    int bits[5] = '{5, 4, 3, 2, 0};

    alag_top #(.LANES(8)) dut_u (
        .mclk_in(mclk_in), .rst_in(rst_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in),
        .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_sel_in(wb_sel_in),
        .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
        .lane_fifo_err_in(lane_fifo_err_in), .lane_active_in(lane_active_in),
        .spll_locked_in(spll_locked_in), .link_data_state_in(link_data_state_in),
        .link_realign_in(link_realign_in), .sysref_realign_in(sysref_realign_in),
        .div_mismatch_in(div_mismatch_in), .cal_status_in(cal_status_in),
        .status_output_pin_out(status_output_pin_out), .irq_out(irq_out)
    );

    // 100 MHz clock
    always #5 mclk_in = ~mclk_in;

    // hang guard
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            $display("ERROR %0t: timeout", $time);
            complete_run();
        end
    end

    // compare one byte and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one classic wishbone cycle, held until ack is seen
    task automatic xfer(input logic we, input logic [9:0] idx, input logic [7:0] wd,
                        output logic [7:0] rd);
        @(posedge mclk_in);
        wb_cyc_in <= 1'b1;
        wb_stb_in <= 1'b1;
        wb_we_in <= we;
        wb_adr_in <= {idx, 2'b00};
        wb_dat_in <= {24'h000000, wd};
        // ack sampled at rising edges only; the hang guard ends a lost ack
        do begin
            @(posedge mclk_in);
        end while (wb_ack_out !== 1'b1);
        rd = wb_dat_out[7:0];
        wb_cyc_in <= 1'b0;
        wb_stb_in <= 1'b0;
        wb_we_in <= 1'b0;
        // let the landed write settle on the outputs
        @(negedge mclk_in);
    endtask : xfer

    task automatic wr(input logic [9:0] idx, input logic [7:0] v);
        logic [7:0] d;
        xfer(1'b1, idx, v, d);
    endtask : wr

    task automatic rd(input logic [9:0] idx, input logic [7:0] exp);
        logic [7:0] d;
        xfer(1'b0, idx, 8'h00, d);
        chk(d, exp);
    endtask : rd

    // raise or drop the fault condition behind one flag bit
    task automatic cond(input int k, input logic on);
        @(posedge mclk_in);
        case (k)
            5: lane_fifo_err_in <= on ? 8'h04 : 8'h00;
            4: spll_locked_in <= !on;
            3: link_data_state_in <= !on;
            2: sysref_realign_in <= on;
            0: div_mismatch_in <= on;
            default: link_realign_in <= on;
        endcase
    endtask : cond

    task automatic pulse(input int k);
        cond(k, 1'b1);
        cond(k, 1'b0);
    endtask : pulse

    // register values straight after reset
    task automatic t_reset();
        rd(ALAG_IDX_FLAGS, 8'h3F);
        rd(ALAG_IDX_MASK, 8'h3F);
        rd(ALAG_IDX_LANE, 8'hFF);
        rd(ALAG_IDX_SUMMARY, 8'h00);
        chk({7'h00, irq_out}, 8'h00);
        chk({7'h00, status_output_pin_out}, 8'h01);
    endtask : t_reset

    // link on, flags cleared, then each source sets its own bit, read back after the other bits are cleared
    task automatic t_sources();
        wr(ALAG_IDX_CTRL, 8'h01);
        wr(ALAG_IDX_FLAGS, 8'h3F);
        rd(ALAG_IDX_FLAGS, 8'h00);
        foreach (bits[i]) begin
            pulse(bits[i]);
            wr(ALAG_IDX_FLAGS, ~(8'h01 << bits[i]) & 8'h3F);
            rd(ALAG_IDX_FLAGS, 8'h01 << bits[i]);
            wr(ALAG_IDX_FLAGS, 8'h01 << bits[i]);
            rd(ALAG_IDX_FLAGS, 8'h00);
        end
    endtask : t_sources

    // per-lane bits and their clear through the fifo flag
    task automatic t_lanes();
        wr(ALAG_IDX_LANE, 8'hFF);
        pulse(5);
        rd(ALAG_IDX_LANE, 8'h04);
        wr(ALAG_IDX_LANE, 8'h04);
        rd(ALAG_IDX_LANE, 8'h00);
        pulse(5);
        wr(ALAG_IDX_FLAGS, 8'h20);
        rd(ALAG_IDX_LANE, 8'h00);
        rd(ALAG_IDX_FLAGS, 8'h00);
        // error on an inactive lane is ignored
        @(posedge mclk_in);
        lane_active_in <= 8'hFB;
        pulse(5);
        rd(ALAG_IDX_LANE, 8'h00);
        rd(ALAG_IDX_FLAGS, 8'h00);
        @(posedge mclk_in);
        lane_active_in <= 8'hFF;
    endtask : t_lanes

    // summary, masking, pin routing and the interrupt line
    task automatic t_summary();
        @(posedge mclk_in);
        cal_status_in <= 1'b0;
        wr(ALAG_IDX_ICLR, 8'hFF);
        wr(ALAG_IDX_MASK, 8'h3B);
        rd(ALAG_IDX_SUMMARY, 8'h00);
        pulse(2);
        rd(ALAG_IDX_SUMMARY, 8'h01);
        chk({7'h00, status_output_pin_out}, 8'h00);
        wr(ALAG_IDX_CTRL, 8'h05);
        chk({7'h00, status_output_pin_out}, 8'h01);
        rd(ALAG_IDX_ISTAT, 8'h04);
        chk({7'h00, irq_out}, 8'h00);
        wr(ALAG_IDX_IEN, 8'h04);
        chk({7'h00, irq_out}, 8'h01);
        wr(ALAG_IDX_MASK, 8'h3F);
        rd(ALAG_IDX_SUMMARY, 8'h00);
        chk({7'h00, status_output_pin_out}, 8'h00);
        wr(ALAG_IDX_ICLR, 8'h04);
        chk({7'h00, irq_out}, 8'h00);
        wr(ALAG_IDX_FLAGS, 8'h04);
        wr(ALAG_IDX_CTRL, 8'h01);
    endtask : t_summary

    // 64b66b: startup and realignment both set the link flag
    task automatic t_mode66();
        wr(ALAG_IDX_CTRL, 8'h02);
        wr(ALAG_IDX_CTRL, 8'h03);
        rd(ALAG_IDX_FLAGS, 8'h08);
        wr(ALAG_IDX_FLAGS, 8'h08);
        rd(ALAG_IDX_FLAGS, 8'h00);
        pulse(1);
        rd(ALAG_IDX_FLAGS, 8'h08);
        wr(ALAG_IDX_FLAGS, 8'h08);
        wr(ALAG_IDX_CTRL, 8'h01);
    endtask : t_mode66

    // condition present during the clearing write keeps the flag
    task automatic t_sticky();
        cond(4, 1'b1);
        wr(ALAG_IDX_FLAGS, 8'h10);
        rd(ALAG_IDX_FLAGS, 8'h10);
        cond(4, 1'b0);
        wr(ALAG_IDX_FLAGS, 8'h10);
        rd(ALAG_IDX_FLAGS, 8'h00);
    endtask : t_sticky

    // soft reset, read-only and unmapped places
    task automatic t_soft();
        wr(ALAG_IDX_MASK, 8'h00);
        wr(ALAG_IDX_SUMMARY, 8'hFF);
        rd(ALAG_IDX_SUMMARY, 8'h00);
        wr(ALAG_IDX_CTRL, 8'h80);
        rd(ALAG_IDX_FLAGS, 8'h3F);
        rd(ALAG_IDX_MASK, 8'h3F);
        rd(ALAG_IDX_CTRL, 8'h00);
        rd(ALAG_IDX_SUMMARY, 8'h00);
        rd(10'h3FF, 8'h00);
    endtask : t_soft

    // verdict and end of run
    task automatic complete_run();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    // main sequence
    initial begin
        repeat (16) @(posedge mclk_in);
        rst_in <= 1'b0;
        t_reset();
        t_sources();
        t_lanes();
        t_summary();
        t_mode66();
        t_sticky();
        t_soft();
        complete_run();
    end
endmodule : tb_alag_top
`default_nettype wire
